//--- verif/tb_cdr_tuning_register_bank.sv
`timescale 1ns/1ps
module tb_cdr_tuning_register_bank;
  import cdr_tuning_pkg::*;

  // Stimulus and observed signals.
  logic              core_clk_i = 1'b0;
  logic              rst_i      = 1'b1;
  logic [7:0]        reg_addr_i = 8'h00;
  logic              reg_wr_i   = 1'b0;
  logic [7:0]        reg_wdata_i = 8'h00;
  logic              reg_rd_i   = 1'b0;
  logic [7:0]        reg_rdata_o;
  logic [2:0]        recovery_mode_code_i = MODE_LOCK_DATA;
  logic              high_rate_i = 1'b0;
  logic              ref_op, lol_data, ratio_ok, rise_en, fall_en, adapt_thr;
  logic              ext_thr, thr_en, term_fl, sel_bad, adapt_gain;
  logic [1:0]        band, slew, in_sel;
  logic [3:0]        ratio, gain;
  logic [2:0]        bw;
  logic signed [3:0] phase;
  logic [6:0]        level;
  int                n_fail = 0;
  int                checks_done = 0;

  // Device under test.
  cdr_tuning_register_bank #(.ADDR_W(8)) u_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .recovery_mode_code_i(recovery_mode_code_i), .high_rate_i(high_rate_i),
    .reference_locked_operation_o(ref_op), .lock_loss_vs_data_o(lol_data),
    .reference_band_o(band), .rate_ratio_code_o(ratio), .ratio_code_valid_o(ratio_ok),
    .rise_edge_en_o(rise_en), .fall_edge_en_o(fall_en), .transfer_bandwidth_scale_o(bw),
    .adaptive_threshold_en_o(adapt_thr), .dll_slew_o(slew), .sample_phase_o(phase),
    .extended_threshold_o(ext_thr), .threshold_level_o(level), .threshold_enable_o(thr_en),
    .term_float_o(term_fl), .input_stage_sel_o(in_sel), .input_sel_illegal_o(sel_bad),
    .adaptive_gain_enable_o(adapt_gain), .equalizer_gain_code_o(gain)
  );

  // Free-running 50 MHz clock.
  always #10 core_clk_i = ~core_clk_i;

  // Compares one value and counts the outcome.
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One write strobe; outputs are settled when the task returns.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  // One read strobe; data is taken 1 ns after the edge that samples the read.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  // A write followed at the next edge by a read of the same offset.
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= wd;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  // Changes a context input off the register port and lets it settle.
  task automatic ctx(input logic [2:0] m, input logic hr);
    @(posedge core_clk_i);
    recovery_mode_code_i <= m;
    high_rate_i          <= hr;
    #1;
  endtask

  // Reset values, then reserved bits dropped on an all-ones write.
  task automatic t_reset_and_masks();
    logic [7:0] a_tab [6] = '{REF_LOCK_ADDR, PHASE_LOOP_ADDR, THR_DLL_ADDR,
                              SAMPLING_ADDR, DECISION_ADDR, INPUT_STAGE_ADDR};
    logic [7:0] r_tab [6] = '{REF_LOCK_RST, PHASE_LOOP_RST, THR_DLL_RST,
                              SAMPLING_RST, DECISION_RST, INPUT_STAGE_RST};
    logic [7:0] m_tab [6] = '{8'h7f, 8'h1f, 8'h07, 8'h0f, 8'hff, 8'hff};
    logic [7:0] d;
    chk("bw_scale_reset", {5'h00, bw}, 8'h04);
    chk("band_reset", {6'h00, band}, 8'h00);
    chk("edges_reset", {6'h00, rise_en, fall_en}, 8'h03);
    chk("thr_en_reset", {7'h00, thr_en}, 8'h00);
    for (int i = 0; i < 6; i++) begin
      rd(a_tab[i], d);
      chk("reg_reset", d, r_tab[i]);
      wr(a_tab[i], 8'hff);
      rd(a_tab[i], d);
      chk("reg_mask", d, m_tab[i]);
      wr(a_tab[i], 8'h00);
    end
  endtask

  // Reference-lock fields, ratio range and mode gating.
  task automatic t_ref_lock();
    ctx(MODE_LOCK_REF, 1'b0);
    wr(REF_LOCK_ADDR, 8'hea);
    chk("ref_op", {7'h00, ref_op}, 8'h01);
    chk("lol_data", {7'h00, lol_data}, 8'h01);
    chk("band", {6'h00, band}, 8'h02);
    chk("ratio", {4'h0, ratio}, 8'h0a);
    chk("ratio_ok_max", {7'h00, ratio_ok}, 8'h01);
    wr(REF_LOCK_ADDR, 8'h3b);
    chk("lol_ref", {7'h00, lol_data}, 8'h00);
    chk("band_top", {6'h00, band}, 8'h03);
    chk("ratio_ok_over", {7'h00, ratio_ok}, 8'h00);
    wr(REF_LOCK_ADDR, 8'h40);
    chk("ratio_ok_zero", {7'h00, ratio_ok}, 8'h01);
    ctx(MODE_LOCK_DATA, 1'b0);
    chk("ref_op_off", {7'h00, ref_op}, 8'h00);
    chk("lol_gated", {7'h00, lol_data}, 8'h00);
  endtask

  // Every edge-select code with a changing bandwidth scale.
  task automatic t_phase_loop();
    logic [2:0] s;
    for (int e = 0; e < 4; e++) begin
      s = 3'(e * 3 + 5);
      wr(PHASE_LOOP_ADDR, {3'h7, 2'(e), s});
      chk("rise_en", {7'h00, rise_en}, {7'h00, e != 2});
      chk("fall_en", {7'h00, fall_en}, {7'h00, e != 1});
      chk("bw_scale", {5'h00, bw}, {5'h00, s});
    end
  endtask

  // Adaptive threshold enable and DLL slew.
  task automatic t_thr_dll();
    logic [7:0] d;
    wr(THR_DLL_ADDR, 8'hfd);
    chk("adapt_thr_on", {7'h00, adapt_thr}, 8'h01);
    chk("slew_1", {6'h00, slew}, 8'h01);
    wr(THR_DLL_ADDR, 8'h02);
    chk("adapt_thr_off", {7'h00, adapt_thr}, 8'h00);
    chk("slew_2", {6'h00, slew}, 8'h02);
    wr_rd(THR_DLL_ADDR, 8'hae, d);
    chk("thr_dll_rb", d, 8'h06);
  endtask

  // Signed sample phase applies only at high rate.
  task automatic t_sampling();
    logic [7:0] d;
    wr(SAMPLING_ADDR, 8'hf9);
    rd(SAMPLING_ADDR, d);
    chk("phase_rb", d, 8'h09);
    chk("phase_low", {4'h0, phase}, 8'h00);
    ctx(MODE_LOCK_DATA, 1'b1);
    chk("phase_neg", {4'h0, phase}, 8'h09);
    wr(SAMPLING_ADDR, 8'h07);
    chk("phase_pos", {4'h0, phase}, 8'h07);
    ctx(MODE_LOCK_DATA, 1'b0);
    chk("phase_off", {4'h0, phase}, 8'h00);
  endtask

  // Threshold range and the all-zero word disabling the offset.
  task automatic t_decision();
    wr(DECISION_ADDR, 8'h80);
    chk("ext_on", {7'h00, ext_thr}, 8'h01);
    chk("thr_en_zero", {7'h00, thr_en}, 8'h00);
    wr(DECISION_ADDR, 8'h01);
    chk("ext_off", {7'h00, ext_thr}, 8'h00);
    chk("level", {1'b0, level}, 8'h01);
    chk("thr_en_one", {7'h00, thr_en}, 8'h01);
  endtask

  // Every input selector code with termination and gain fields.
  task automatic t_input_stage();
    logic [7:0] d;
    for (int s = 0; s < 4; s++) begin
      d = {s[0], 2'(s), s[1], 4'(15 - s * 5)};
      wr(INPUT_STAGE_ADDR, d);
      chk("term_float", {7'h00, term_fl}, {7'h00, d[7]});
      chk("in_sel", {6'h00, in_sel}, 8'(s));
      chk("sel_bad", {7'h00, sel_bad}, {7'h00, s == 3});
      chk("adapt_gain", {7'h00, adapt_gain}, {7'h00, d[4]});
      chk("eq_gain", {4'h0, gain}, {4'h0, d[3:0]});
    end
    wr_rd(INPUT_STAGE_ADDR, 8'h9a, d);
    chk("in_stage_rb", d, 8'h9a);
  endtask

  // Unmapped offsets and a write and read together at one edge.
  task automatic t_access();
    logic [7:0] d;
    wr(8'h17, 8'h55);
    rd(8'h17, d);
    chk("unmapped_rd", d, 8'h00);
    rd(8'h0e, d);
    chk("below_map_rd", d, 8'h00);
    wr(INPUT_STAGE_ADDR, 8'h35);
    @(posedge core_clk_i);
    reg_wdata_i <= 8'h12;
    reg_wr_i    <= 1'b1;
    reg_rd_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1;
    chk("rd_old", reg_rdata_o, 8'h35);
    rd(INPUT_STAGE_ADDR, d);
    chk("rd_new", d, 8'h12);
  endtask

  // Main sequence: reset for six cycles, then each scenario.
  initial begin
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1;
    t_reset_and_masks();
    t_ref_lock();
    t_phase_loop();
    t_thr_dll();
    t_sampling();
    t_decision();
    t_input_stage();
    t_access();
    finish_test();
  end

  // Watchdog well beyond the hundred or so cycles the scenarios need.
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
endmodule

//--- verilog/cdr_field_decode.sv
`timescale 1ns/1ps
// Turns the stored register bytes into the control levels seen by the front end.
module cdr_field_decode (
  // Stored register bytes.
  input  wire logic [7:0]        ref_lock_i,
  input  wire logic [7:0]        phase_loop_i,
  input  wire logic [7:0]        sampling_i,
  input  wire logic [7:0]        decision_i,
  input  wire logic [7:0]        input_stage_i,
  // Device context.
  input  wire logic [2:0]        recovery_mode_code_i,
  input  wire logic              high_rate_i,
  // Decoded controls.
  output logic                   reference_locked_operation_o,
  output logic                   lock_loss_vs_data_o,
  output logic                   ratio_code_valid_o,
  output logic                   rise_edge_en_o,
  output logic                   fall_edge_en_o,
  output logic signed [3:0]      sample_phase_o,
  output logic                   threshold_enable_o,
  output logic                   input_sel_illegal_o
);
  import cdr_tuning_pkg::*;

  wire logic [1:0] edge_field;
  wire logic [3:0] ratio_field;

  assign edge_field  = phase_loop_i[EDGE_LSB +: 2];
  assign ratio_field = ref_lock_i[RATIO_LSB +: 4];

  // Of the reference-lock settings only the lock-loss choice is gated to reference-lock mode; band and ratio are not.
  assign reference_locked_operation_o = (recovery_mode_code_i == MODE_LOCK_REF); // RQ16
  assign lock_loss_vs_data_o = reference_locked_operation_o
                               && ref_lock_i[LOCK_LOSS_BIT];                       // RQ1
  // Codes above the largest ratio have no divider setting behind them.
  assign ratio_code_valid_o = (ratio_field <= RATIO_MAX);                          // RQ3

  // Both-edge codes enable both detectors; single-edge codes disable the other.
  assign rise_edge_en_o = (edge_field != EDGE_FALL);                               // RQ5
  assign fall_edge_en_o = (edge_field != EDGE_RISE);                               // RQ5

  // The offset is signed and only reaches the sampler at the high rates.
  assign sample_phase_o = high_rate_i ? $signed(sampling_i[PHASE_LSB +: 4])
                                      : 4'sh0;                                     // RQ9

  // An all-zero level word switches the threshold offset off.
  assign threshold_enable_o = |decision_i[LEVEL_LSB +: 7];                         // RQ11

  // The undefined selector code is reported so the front end can ignore it.
  assign input_sel_illegal_o = (input_stage_i[INSEL_LSB +: 2] == INSEL_UNDEFINED); // RQ13

endmodule

//--- verilog/cdr_tuning_pkg.sv
// Summary of operation
// RQ1: Lock-loss check bit picks reference clock (0) or incoming data (1) comparison.
// RQ2: Two-bit reference band doubles per code from 11.05-22.1 MHz; resets to 00.
// RQ3: Four-bit ratio code means two to the power of code minus one, up to 512.
// RQ4: Data rate over ratio divider must equal reference over band divider.
// RQ5: Edge select: 00 and 11 both edges, 01 rising only, 10 falling only.
// RQ6: Transfer bandwidth scale resets to 4; bandwidth scales by value over four.
// RQ7: Threshold and DLL register bit D2 enables automatic threshold adjustment.
// RQ8: Two low bits of threshold and DLL register set DLL slew bandwidth.
// RQ9: Sample phase is two's complement, 1/32 UI steps, only above 5.65 Gbps.
// RQ10: Decision level bit D7 selects normal (0) or extended (1) threshold range.
// RQ11: Threshold word of all zeros disables the threshold offset function.
// RQ12: Input stage bit D7 drives (0) or floats (1) termination common mode.
// RQ13: Input selector 00 limiter, 01 equalizer, 10 buffer; 11 never written.
// RQ14: Input stage bit D4 picks manual (0) or adaptive (1) equalizer gain.
// RQ15: Four low bits of input stage register set equalizer gain.
// RQ16: Reference-lock settings act only while recovery mode code holds 011; only the lock-loss bit is gated, band and ratio are not.
package cdr_tuning_pkg;

  // Register offsets.
  localparam logic [7:0] REF_LOCK_ADDR    = 8'h0f;
  localparam logic [7:0] PHASE_LOOP_ADDR  = 8'h10;
  localparam logic [7:0] THR_DLL_ADDR     = 8'h13;
  localparam logic [7:0] SAMPLING_ADDR    = 8'h14;
  localparam logic [7:0] DECISION_ADDR    = 8'h15;
  localparam logic [7:0] INPUT_STAGE_ADDR = 8'h16;

  // Writable bits of each register; reserved bits store nothing and read as zero.
  localparam logic [7:0] REF_LOCK_MASK    = 8'h7f;
  localparam logic [7:0] PHASE_LOOP_MASK  = 8'h1f;
  localparam logic [7:0] THR_DLL_MASK     = 8'h07;
  localparam logic [7:0] SAMPLING_MASK    = 8'h0f;
  localparam logic [7:0] DECISION_MASK    = 8'hff;
  localparam logic [7:0] INPUT_STAGE_MASK = 8'hff;

  // Reset values.
  localparam logic [7:0] REF_LOCK_RST    = 8'h00;
  localparam logic [7:0] PHASE_LOOP_RST  = 8'h04;
  localparam logic [7:0] THR_DLL_RST     = 8'h00;
  localparam logic [7:0] SAMPLING_RST    = 8'h00;
  localparam logic [7:0] DECISION_RST    = 8'h00;
  localparam logic [7:0] INPUT_STAGE_RST = 8'h00;

  // Field positions.
  localparam int LOCK_LOSS_BIT   = 6;
  localparam int BAND_LSB        = 4;
  localparam int RATIO_LSB       = 0;
  localparam int EDGE_LSB        = 3;
  localparam int BW_LSB          = 0;
  localparam int ADAPT_THR_BIT   = 2;
  localparam int SLEW_LSB        = 0;
  localparam int PHASE_LSB       = 0;
  localparam int EXT_THR_BIT     = 7;
  localparam int LEVEL_LSB       = 0;
  localparam int TERM_FLOAT_BIT  = 7;
  localparam int INSEL_LSB       = 5;
  localparam int ADAPT_GAIN_BIT  = 4;
  localparam int GAIN_LSB        = 0;

  // Largest meaningful ratio code and the bandwidth scale at unity.
  localparam logic [3:0] RATIO_MAX  = 4'ha;
  localparam logic [2:0] BW_UNITY   = 3'h4;

  // Recovery mode codes held elsewhere in the device.
  typedef enum logic [2:0] {
    MODE_LOCK_DATA = 3'b001,
    MODE_LOCK_REF  = 3'b011
  } recovery_mode_type;

  // Phase detector edge choice.
  typedef enum logic [1:0] {
    EDGE_BOTH     = 2'b00,
    EDGE_RISE     = 2'b01,
    EDGE_FALL     = 2'b10,
    EDGE_BOTH_ALT = 2'b11
  } edge_sel_type;

  // Front end choice.
  typedef enum logic [1:0] {
    INSEL_LIMITER   = 2'b00,
    INSEL_EQUALIZER = 2'b01,
    INSEL_BUFFER    = 2'b10,
    INSEL_UNDEFINED = 2'b11
  } input_sel_type;

  // Masks a write to a register, keeping reserved bits at zero.
  function automatic logic [7:0] masked_write(input logic [7:0] data,
                                              input logic [7:0] mask);
    masked_write = data & mask;
  endfunction

endpackage

//--- verilog/cdr_tuning_register_bank.sv
`timescale 1ns/1ps
// Configuration registers for the clock-recovery receiver and its front end.
module cdr_tuning_register_bank #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  // Register access port.
  input  wire logic [ADDR_W-1:0]     reg_addr_i,
  input  wire logic                  reg_wr_i,
  input  wire logic [7:0]            reg_wdata_i,
  input  wire logic                  reg_rd_i,
  output logic [7:0]                 reg_rdata_o,
  // Device context.
  input  wire logic [2:0]            recovery_mode_code_i,
  input  wire logic                  high_rate_i,
  // Reference-lock controls.
  output logic                       reference_locked_operation_o,
  output logic                       lock_loss_vs_data_o,
  output logic [1:0]                 reference_band_o,
  output logic [3:0]                 rate_ratio_code_o,
  output logic                       ratio_code_valid_o,
  // Phase loop controls.
  output logic                       rise_edge_en_o,
  output logic                       fall_edge_en_o,
  output logic [2:0]                 transfer_bandwidth_scale_o,
  output logic                       adaptive_threshold_en_o,
  output logic [1:0]                 dll_slew_o,
  output logic signed [3:0]          sample_phase_o,
  // Decision threshold controls.
  output logic                       extended_threshold_o,
  output logic [6:0]                 threshold_level_o,
  output logic                       threshold_enable_o,
  // Input stage controls.
  output logic                       term_float_o,
  output logic [1:0]                 input_stage_sel_o,
  output logic                       input_sel_illegal_o,
  output logic                       adaptive_gain_enable_o,
  output logic [3:0]                 equalizer_gain_code_o
);
  import cdr_tuning_pkg::*;

  // The highest offset must fit in the address port.
  initial begin
    if (ADDR_W < 5 || ADDR_W > 8) begin
      $error("ADDR_W must lie between 5 and 8");
    end
  end

  logic [7:0] ref_lock_r;
  logic [7:0] phase_loop_r;
  logic [7:0] thr_dll_r;
  logic [7:0] sampling_r;
  logic [7:0] decision_r;
  logic [7:0] input_stage_r;
  logic [7:0] rdata_r;

  wire logic [7:0] addr_full;
  wire logic       hit_ref_lock;
  wire logic       hit_phase_loop;
  wire logic       hit_thr_dll;
  wire logic       hit_sampling;
  wire logic       hit_decision;
  wire logic       hit_input_stage;
  wire logic [7:0] read_mux;

  // Address decode; the port is widened to the byte offsets of the map.
  assign addr_full       = 8'(reg_addr_i);
  assign hit_ref_lock    = (addr_full == REF_LOCK_ADDR);
  assign hit_phase_loop  = (addr_full == PHASE_LOOP_ADDR);
  assign hit_thr_dll     = (addr_full == THR_DLL_ADDR);
  assign hit_sampling    = (addr_full == SAMPLING_ADDR);
  assign hit_decision    = (addr_full == DECISION_ADDR);
  assign hit_input_stage = (addr_full == INPUT_STAGE_ADDR);

  // Read selection; unmapped offsets read as zero.
  assign read_mux = hit_ref_lock    ? ref_lock_r    :
                    hit_phase_loop  ? phase_loop_r  :
                    hit_thr_dll     ? thr_dll_r     :
                    hit_sampling    ? sampling_r    :
                    hit_decision    ? decision_r    :
                    hit_input_stage ? input_stage_r : 8'h00;

  // Reference-lock register: lock-loss source, band and ratio.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_lock_r <= REF_LOCK_RST;                                 // RQ2
    end else if (reg_wr_i && hit_ref_lock) begin
      ref_lock_r <= masked_write(reg_wdata_i, REF_LOCK_MASK);     // RQ1
    end
  end

  // Phase loop register: edge choice and bandwidth scale.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_loop_r <= PHASE_LOOP_RST;                             // RQ6
    end else if (reg_wr_i && hit_phase_loop) begin
      phase_loop_r <= masked_write(reg_wdata_i, PHASE_LOOP_MASK); // RQ5
    end
  end

  // Threshold adaptation and DLL slew register.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      thr_dll_r <= THR_DLL_RST;
    end else if (reg_wr_i && hit_thr_dll) begin
      thr_dll_r <= masked_write(reg_wdata_i, THR_DLL_MASK);       // RQ7
    end
  end

  // Sample phase offset register.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sampling_r <= SAMPLING_RST;
    end else if (reg_wr_i && hit_sampling) begin
      sampling_r <= masked_write(reg_wdata_i, SAMPLING_MASK);     // RQ9
    end
  end

  // Decision level register: range and threshold word.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      decision_r <= DECISION_RST;
    end else if (reg_wr_i && hit_decision) begin
      decision_r <= masked_write(reg_wdata_i, DECISION_MASK);     // RQ10
    end
  end

  // Input stage register: termination, selector, gain mode and gain.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      input_stage_r <= INPUT_STAGE_RST;
    end else if (reg_wr_i && hit_input_stage) begin
      input_stage_r <= masked_write(reg_wdata_i, INPUT_STAGE_MASK); // RQ12
    end
  end

  // Read data is captured at the clock edge that samples the read strobe and then held.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_r <= read_mux;
    end
  end

  assign reg_rdata_o = rdata_r;

  // Plain fields go straight from the stored bits to the analogue controls.
  assign reference_band_o           = ref_lock_r[BAND_LSB +: 2];       // RQ2
  assign rate_ratio_code_o          = ref_lock_r[RATIO_LSB +: 4];      // RQ4
  assign transfer_bandwidth_scale_o = phase_loop_r[BW_LSB +: 3];       // RQ6
  assign adaptive_threshold_en_o    = thr_dll_r[ADAPT_THR_BIT];        // RQ7
  assign dll_slew_o                 = thr_dll_r[SLEW_LSB +: 2];        // RQ8
  assign extended_threshold_o       = decision_r[EXT_THR_BIT];         // RQ10
  assign threshold_level_o          = decision_r[LEVEL_LSB +: 7];      // RQ11
  assign term_float_o               = input_stage_r[TERM_FLOAT_BIT];   // RQ12
  assign input_stage_sel_o          = input_stage_r[INSEL_LSB +: 2];   // RQ13
  assign adaptive_gain_enable_o     = input_stage_r[ADAPT_GAIN_BIT];   // RQ14
  assign equalizer_gain_code_o      = input_stage_r[GAIN_LSB +: 4];    // RQ15

  // Decoded and gated controls.
  cdr_field_decode u_decode (
    .ref_lock_i                   (ref_lock_r),
    .phase_loop_i                 (phase_loop_r),
    .sampling_i                   (sampling_r),
    .decision_i                   (decision_r),
    .input_stage_i                (input_stage_r),
    .recovery_mode_code_i         (recovery_mode_code_i),
    .high_rate_i                  (high_rate_i),
    .reference_locked_operation_o (reference_locked_operation_o),
    .lock_loss_vs_data_o          (lock_loss_vs_data_o),
    .ratio_code_valid_o           (ratio_code_valid_o),
    .rise_edge_en_o               (rise_edge_en_o),
    .fall_edge_en_o               (fall_edge_en_o),
    .sample_phase_o               (sample_phase_o),
    .threshold_enable_o           (threshold_enable_o),
    .input_sel_illegal_o          (input_sel_illegal_o)
  );

  // A lock-loss data choice reaches the output only in reference-lock mode.
  lock_loss_source_a: assert property ( // RQ1
    @(posedge core_clk_i) disable iff (rst_i)
    reg_wr_i && hit_ref_lock ##1 (recovery_mode_code_i == MODE_LOCK_REF)
    |-> lock_loss_vs_data_o == $past(reg_wdata_i[LOCK_LOSS_BIT]))
    else $error("lock-loss source does not follow the written bit");

  // The band field comes out of reset at its lowest code.
  band_reset_a: assert property ( // RQ2
    @(posedge core_clk_i) disable iff (rst_i)
    $fell(rst_i) |-> reference_band_o == 2'b00)
    else $error("reference band not at lowest code after reset");

  // Ratio codes beyond the table are flagged.
  ratio_range_a: assert property ( // RQ3
    @(posedge core_clk_i) disable iff (rst_i)
    ratio_code_valid_o == (rate_ratio_code_o <= 4'ha))
    else $error("ratio validity flag wrong");

  // The rising-only code shuts the falling detector off.
  edge_choice_a: assert property ( // RQ5
    @(posedge core_clk_i) disable iff (rst_i)
    reg_wr_i && hit_phase_loop && reg_wdata_i[4:3] == 2'b01
    |=> rise_edge_en_o && !fall_edge_en_o)
    else $error("rising-only edge choice not applied");

  // Bandwidth scale comes out of reset at unity.
  bw_reset_a: assert property ( // RQ6
    @(posedge core_clk_i) disable iff (rst_i)
    $fell(rst_i) |-> transfer_bandwidth_scale_o == 3'h4)
    else $error("bandwidth scale not four after reset");

  // Reserved bits of the threshold and DLL register read back as zero.
  thr_dll_read_a: assert property ( // RQ7
    @(posedge core_clk_i) disable iff (rst_i)
    reg_wr_i && hit_thr_dll ##1 reg_rd_i && hit_thr_dll
    |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h07))
    else $error("threshold and DLL register readback wrong");

  // Phase offset is zero once the rate has been low for two cycles in a row.
  phase_gate_a: assert property ( // RQ9
    @(posedge core_clk_i) disable iff (rst_i)
    !high_rate_i [*2] |-> sample_phase_o == 4'sh0)
    else $error("sample phase applied below the high rate");

  // An all-zero level word disables the threshold offset.
  thr_zero_off_a: assert property ( // RQ11
    @(posedge core_clk_i) disable iff (rst_i)
    reg_wr_i && hit_decision && reg_wdata_i[6:0] == 7'h00
    |=> !threshold_enable_o && threshold_level_o == 7'h00)
    else $error("threshold not disabled at zero level");

  // The undefined selector code is reported.
  insel_flag_a: assert property ( // RQ13
    @(posedge core_clk_i) disable iff (rst_i)
    input_sel_illegal_o == (input_stage_sel_o == 2'b11))
    else $error("undefined input selector not flagged");

  // A write to the input stage register reads back two cycles later.
  input_stage_read_a: assert property ( // RQ14
    @(posedge core_clk_i) disable iff (rst_i)
    reg_wr_i && hit_input_stage ##1 reg_rd_i && hit_input_stage && !reg_wr_i
    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("input stage readback wrong");

  // Lock-to-data mode code 001 clears the reference-lock indication and the lock-loss choice.
  ref_mode_a: assert property ( // RQ16
    @(posedge core_clk_i) disable iff (rst_i)
    recovery_mode_code_i == 3'b001 |-> !reference_locked_operation_o && !lock_loss_vs_data_o)
    else $error("reference-lock settings active in lock-to-data mode");

  // Band and ratio fields take the written bits at the next cycle.
  ref_fields_a: assert property ( // RQ2 RQ3
    @(posedge core_clk_i) disable iff (rst_i)
    reg_wr_i && hit_ref_lock
    |=> reference_band_o == $past(reg_wdata_i[5:4]) && rate_ratio_code_o == $past(reg_wdata_i[3:0]))
    else $error("reference band or ratio not stored");

  // The falling-only code shuts the rising detector off.
  fall_only_a: assert property ( // RQ5
    @(posedge core_clk_i) disable iff (rst_i)
    reg_wr_i && hit_phase_loop && reg_wdata_i[4:3] == 2'b10
    |=> !rise_edge_en_o && fall_edge_en_o)
    else $error("falling-only edge choice not applied");

  // Adaptive threshold enable and DLL slew take the written bits.
  thr_dll_fields_a: assert property ( // RQ7 RQ8
    @(posedge core_clk_i) disable iff (rst_i)
    reg_wr_i && hit_thr_dll
    |=> dll_slew_o == $past(reg_wdata_i[1:0]) && adaptive_threshold_en_o == $past(reg_wdata_i[2]))
    else $error("threshold adaptation or DLL slew not stored");

  // A written phase offset reaches the sampler at the high rates.
  phase_high_a: assert property ( // RQ9
    @(posedge core_clk_i) disable iff (rst_i)
    reg_wr_i && hit_sampling ##1 high_rate_i
    |-> $unsigned(sample_phase_o) == $past(reg_wdata_i[3:0]))
    else $error("sample phase not applied at high rate");

  // The range bit takes the written value.
  ext_thr_write_a: assert property ( // RQ10
    @(posedge core_clk_i) disable iff (rst_i)
    reg_wr_i && hit_decision |=> extended_threshold_o == $past(reg_wdata_i[7]))
    else $error("threshold range bit not stored");

  // A nonzero level word turns the threshold offset on.
  thr_level_on_a: assert property ( // RQ11
    @(posedge core_clk_i) disable iff (rst_i)
    reg_wr_i && hit_decision && reg_wdata_i[6:0] != 7'h00
    |=> threshold_enable_o && threshold_level_o == $past(reg_wdata_i[6:0]))
    else $error("threshold not enabled at nonzero level");

  // Termination and selector fields take the written bits.
  term_sel_write_a: assert property ( // RQ12
    @(posedge core_clk_i) disable iff (rst_i)
    reg_wr_i && hit_input_stage
    |=> term_float_o == $past(reg_wdata_i[7]) && input_stage_sel_o == $past(reg_wdata_i[6:5]))
    else $error("termination or selector not stored");

  // Gain mode and gain code take the written bits.
  gain_write_a: assert property ( // RQ14 RQ15
    @(posedge core_clk_i) disable iff (rst_i)
    reg_wr_i && hit_input_stage
    |=> adaptive_gain_enable_o == $past(reg_wdata_i[4])
        && equalizer_gain_code_o == $past(reg_wdata_i[3:0]))
    else $error("equalizer gain settings not stored");

endmodule
